/* File: hw/uvf_fault_response.v */
`timescale 1ns/1ns
`default_nettype none
`include "uvf_consts.vh"

module uvf_fault_response (
   // clock and reset
   input  wire       i_clk_sys,
   input  wire       i_rst,
   // register port from serial interface
   input  wire       i_reg_wr_en,
   input  wire [7:0] i_reg_addr,
   input  wire [7:0] i_reg_wdata,
   output wire [7:0] o_reg_rdata,
   // analog and power stage pins
   input  wire       i_en,
   input  wire       i_sw_tick,
   input  wire       i_fb_below_half,
   input  wire       i_fb_below_3q,
   input  wire       i_vout_falling,
   input  wire       i_ss_done,
   input  wire       i_otp,
   input  wire       i_oc_event,
   // converter control
   output wire       o_switch_enable,
   output wire       o_soft_start,
   output wire       o_hiccup,
   output wire       o_latched_off,
   output wire       o_uv_fault,
   output wire       o_current_limit_en,
   output wire       o_oc_response_apply,
   output wire       o_uv_threshold_select,
   // input overvoltage settings
   output wire       o_input_ov_enable,
   output wire [1:0] o_input_ov_threshold,
   output wire       o_input_ov_hysteresis
);

   localparam [5:0] ST_STOP   = 6'h01;
   localparam [5:0] ST_SS     = 6'h02;
   localparam [5:0] ST_RUN    = 6'h04;
   localparam [5:0] ST_DELAY  = 6'h08;
   localparam [5:0] ST_HICCUP = 6'h10;
   localparam [5:0] ST_LATCH  = 6'h20;

   reg  [7:0]            uv_cfg_reg;
   reg  [7:0]            ov_cfg_reg;
   reg  [7:0]            rdata_reg;
   reg  [7:0]            rdata_next;
   reg  [`UVF_PIN_W-1:0] pin_meta_reg;
   reg  [`UVF_PIN_W-1:0] pin_sync_reg;
   reg                   tick_prev_reg;
   reg  [5:0]            state_reg;
   reg  [5:0]            state_next;
   reg                   retried_reg;
   reg                   retried_next;
   reg  [`UVF_DLY_W-1:0] dly_reg;
   reg  [`UVF_DLY_W-1:0] dly_next;
   reg                   uv_out_reg;
   reg                   sw_out_reg;
   reg                   ss_out_reg;
   reg                   hic_out_reg;
   reg                   latch_out_reg;
   reg                   oc_out_reg;

   wire       en_s;
   wire       tick_s;
   wire       otp_s;
   wire       oc_s;
   wire       tick;
   wire       uv_sel;
   wire [1:0] uv_mode;
   wire       uv_below;
   wire       uv_cond;
   wire       uv_trip;
   wire       in_ss;

   // configuration registers
   always @(posedge i_clk_sys) begin
      if (i_rst) begin
         uv_cfg_reg <= `UVF_UV_CFG_RESET;
         ov_cfg_reg <= `UVF_OV_CFG_RESET;
      end else if (i_reg_wr_en) begin
         if (i_reg_addr == `UVF_ADDR_UV_CFG)
            uv_cfg_reg <= i_reg_wdata;
         if (i_reg_addr == `UVF_ADDR_OV_CFG)
            ov_cfg_reg <= i_reg_wdata;
      end
   end

   always @* begin
      case (i_reg_addr)
         `UVF_ADDR_UV_CFG: rdata_next = uv_cfg_reg;
         `UVF_ADDR_OV_CFG: rdata_next = ov_cfg_reg;
         `UVF_ADDR_STATUS: rdata_next = {2'h0, state_reg};
         default:          rdata_next = `UVF_RDATA_NONE;
      endcase
   end

   // two-stage pin synchroniser
   always @(posedge i_clk_sys) begin
      if (i_rst) begin
         pin_meta_reg  <= `UVF_PIN_RESET;
         pin_sync_reg  <= `UVF_PIN_RESET;
         tick_prev_reg <= 1'b0;
         rdata_reg     <= `UVF_RDATA_NONE;
      end else begin
         pin_meta_reg  <= {i_oc_event, i_otp, i_ss_done, i_vout_falling,
                           i_fb_below_3q, i_fb_below_half, i_sw_tick, i_en};
         pin_sync_reg  <= pin_meta_reg;
         tick_prev_reg <= tick_s;
         rdata_reg     <= rdata_next;
      end
   end

   assign en_s    = pin_sync_reg[`UVF_PIN_EN];
   assign tick_s  = pin_sync_reg[`UVF_PIN_TICK];
   assign otp_s   = pin_sync_reg[`UVF_PIN_OTP];
   assign oc_s    = pin_sync_reg[`UVF_PIN_OC];
   assign tick    = tick_s & ~tick_prev_reg;

   assign uv_sel  = uv_cfg_reg[`UVF_UV_SEL_BIT];
   assign uv_mode = uv_cfg_reg[`UVF_UV_MODE_HI:`UVF_UV_MODE_LO];
   assign in_ss   = (state_reg == ST_SS);

   // trip level: three quarters when set, else half
   assign uv_below = uv_sel ? pin_sync_reg[`UVF_PIN_3Q]
                            : pin_sync_reg[`UVF_PIN_HALF];
   // only on a falling output, never during soft start, oc has priority
   assign uv_cond  = uv_below & pin_sync_reg[`UVF_PIN_FALL]
                   & ~in_ss
                   & ~oc_s
                   & (state_reg == ST_RUN);

   uvf_debounce u_debounce (
      .i_clk_sys   (i_clk_sys),
      .i_rst       (i_rst),
      .i_cond      (uv_cond),
      .i_tick      (tick),
      .i_count_sel (uv_cfg_reg[`UVF_UV_CNT_HI:`UVF_UV_CNT_LO]),
      .o_trip      (uv_trip)
   );

   // response state machine, held off while enable is low
   always @* begin
      state_next   = state_reg;
      retried_next = retried_reg;
      dly_next     = dly_reg;
      case (state_reg)
         ST_STOP: begin
            retried_next = 1'b0;
            if (en_s)
               state_next = ST_SS;
         end
         ST_SS: begin
            if (pin_sync_reg[`UVF_PIN_SSDONE])
               state_next = ST_RUN;
         end
         ST_RUN: begin
            if (uv_trip) begin
               dly_next = `UVF_RETRY_PERIODS;
               if (uv_mode == `UVF_MODE_LATCH)
                  state_next = ST_LATCH;
               else if (uv_mode == `UVF_MODE_RECOVER) begin
                  state_next   = retried_reg ? ST_HICCUP : ST_DELAY;
                  retried_next = 1'b1;
               end
               // other modes keep switching
            end
         end
         ST_DELAY, ST_HICCUP: begin
            if (dly_reg == `UVF_DLY_ZERO)
               state_next = ST_SS;
            else if (tick)
               dly_next = dly_reg - `UVF_DLY_ONE;
         end
         ST_LATCH: begin
            state_next = ST_LATCH;
         end
         default: begin
            state_next = ST_STOP;
         end
      endcase
      if (!en_s)
         state_next = ST_STOP;
   end

   always @(posedge i_clk_sys) begin
      if (i_rst) begin
         state_reg   <= ST_STOP;
         retried_reg <= 1'b0;
         dly_reg     <= `UVF_DLY_ZERO;
      end else begin
         state_reg   <= state_next;
         retried_reg <= retried_next;
         dly_reg     <= dly_next;
      end
   end

   // registered control outputs
   always @(posedge i_clk_sys) begin
      if (i_rst) begin
         uv_out_reg    <= 1'b0;
         sw_out_reg    <= 1'b0;
         ss_out_reg    <= 1'b0;
         hic_out_reg   <= 1'b0;
         latch_out_reg <= 1'b0;
         oc_out_reg    <= 1'b0;
      end else begin
         uv_out_reg    <= uv_trip;
         sw_out_reg    <= ((state_next == ST_RUN) | (state_next == ST_SS))
                          & ~otp_s;
         ss_out_reg    <= (state_next == ST_SS);
         hic_out_reg   <= (state_next == ST_HICCUP);
         latch_out_reg <= (state_next == ST_LATCH);
         oc_out_reg    <= oc_s;
      end
   end

   assign o_reg_rdata           = rdata_reg;
   assign o_uv_fault            = uv_out_reg;
   assign o_switch_enable       = sw_out_reg;
   assign o_soft_start          = ss_out_reg;
   assign o_hiccup              = hic_out_reg;
   assign o_latched_off         = latch_out_reg;
   assign o_oc_response_apply   = oc_out_reg;
   // current limits stay armed whenever switching, soft start included
   assign o_current_limit_en    = sw_out_reg;
   assign o_uv_threshold_select = uv_cfg_reg[`UVF_UV_SEL_BIT];
   assign o_input_ov_hysteresis = ov_cfg_reg[`UVF_OV_HYS_BIT];
   assign o_input_ov_threshold  = ov_cfg_reg[`UVF_OV_THR_HI:`UVF_OV_THR_LO];
   assign o_input_ov_enable     = (ov_cfg_reg[`UVF_OV_THR_HI:`UVF_OV_THR_LO]
                                   != `UVF_OV_THR_OFF);

endmodule // uvf_fault_response
`default_nettype wire

/* File: hw/uvf_consts.vh */
`ifndef UVF_CONSTS_VH
`define UVF_CONSTS_VH

// register addresses
`define UVF_ADDR_UV_CFG    8'h0C
`define UVF_ADDR_OV_CFG    8'h0D
`define UVF_ADDR_STATUS    8'h40
`define UVF_UV_CFG_RESET   8'h00
`define UVF_OV_CFG_RESET   8'h00
`define UVF_RDATA_NONE     8'h00

// undervoltage config fields
`define UVF_UV_SEL_BIT     4
`define UVF_UV_CNT_HI      3
`define UVF_UV_CNT_LO      2
`define UVF_UV_MODE_HI     1
`define UVF_UV_MODE_LO     0

// overvoltage config fields
`define UVF_OV_HYS_BIT     7
`define UVF_OV_THR_HI      6
`define UVF_OV_THR_LO      5
`define UVF_OV_THR_OFF     2'h0

// response modes
`define UVF_MODE_RECOVER   2'h0
`define UVF_MODE_LATCH     2'h1

// debounce counter
`define UVF_DB_W           5
`define UVF_DB_BASE        5'h02
`define UVF_DB_ZERO        5'h00
`define UVF_DB_ONE         5'h01

// off time before restart, in switching periods
`define UVF_DLY_W          8
`define UVF_RETRY_PERIODS  8'h40
`define UVF_DLY_ZERO       8'h00
`define UVF_DLY_ONE        8'h01

// pin synchroniser width and bit positions
`define UVF_PIN_W          8
`define UVF_PIN_EN         0
`define UVF_PIN_TICK       1
`define UVF_PIN_HALF       2
`define UVF_PIN_3Q         3
`define UVF_PIN_FALL       4
`define UVF_PIN_SSDONE     5
`define UVF_PIN_OTP        6
`define UVF_PIN_OC         7
`define UVF_PIN_RESET      8'h00

`endif

/* File: hw/uvf_debounce.v */
`timescale 1ns/1ns
`default_nettype none
`include "uvf_consts.vh"

module uvf_debounce (
   // clock and reset
   input  wire                 i_clk_sys,
   input  wire                 i_rst,
   // condition and switching period pulse
   input  wire                 i_cond,
   input  wire                 i_tick,
   input  wire [1:0]           i_count_sel,
   // result
   output wire                 o_trip
);

   reg  [`UVF_DB_W-1:0] count_reg;
   reg  [`UVF_DB_W-1:0] count_next;
   wire [`UVF_DB_W-1:0] target;

   function [`UVF_DB_W-1:0] db_target;
      input [1:0] sel;
      begin
         db_target = `UVF_DB_BASE << sel;
      end
   endfunction

   assign target = db_target(i_count_sel);
   assign o_trip = (count_reg >= target);

   always @* begin
      count_next = count_reg;
      if (!i_cond)
         count_next = `UVF_DB_ZERO;
      else if (i_tick && count_reg < target)
         count_next = count_reg + `UVF_DB_ONE;
   end

   always @(posedge i_clk_sys) begin
      if (i_rst)
         count_reg <= `UVF_DB_ZERO;
      else
         count_reg <= count_next;
   end

endmodule // uvf_debounce
`default_nettype wire

/* File: tb/uvf_fault_response_asserts.sv */
`timescale 1ns/1ns
`default_nettype none
module uvf_fault_response_chk (
   input wire logic       i_clk_sys,
   input wire logic       i_rst,
   input wire logic       i_en,
   input wire logic       i_oc_event,
   input wire logic       i_otp,
   input wire logic       o_switch_enable,
   input wire logic       o_soft_start,
   input wire logic       o_hiccup,
   input wire logic       o_latched_off,
   input wire logic       o_uv_fault,
   input wire logic       o_current_limit_en,
   input wire logic       o_oc_response_apply,
   input wire logic       o_input_ov_enable,
   input wire logic [1:0] o_input_ov_threshold
);
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (i_rst);
   limit_follow_a: assert property (
      o_current_limit_en == o_switch_enable)
      else $error("current limit differs from switching");
   // otp reaches the switch output three edges after the pin
   ss_limit_a: assert property (
      o_soft_start && !$past(i_otp, 3) |-> o_current_limit_en)
      else $error("current limit off during soft start");
   ov_enable_a: assert property (
      o_input_ov_enable == (o_input_ov_threshold != 2'h0))
      else $error("input ov enable does not match threshold");
   hiccup_off_a: assert property (
      o_hiccup |-> !o_switch_enable && !o_soft_start)
      else $error("switching during hiccup");
   restart_cause_a: assert property (
      $rose(o_soft_start) |-> !$past(o_switch_enable))
      else $error("soft start entered while switching");
   latch_off_a: assert property (
      o_latched_off |-> !o_switch_enable && !o_hiccup)
      else $error("switching while latched off");
   latch_hold_a: assert property (
      o_latched_off && i_en && $past(i_en) && $past(i_en, 2)
      && $past(i_en, 3) |=> o_latched_off)
      else $error("latch released with enable high");
   latch_cause_a: assert property (
      $rose(o_latched_off) |-> o_uv_fault || $past(o_uv_fault))
      else $error("latch without undervoltage trip");
   en_stop_a: assert property (
      !i_en [*4] |=> !o_switch_enable && !o_latched_off)
      else $error("enable low did not stop converter");
   oc_quiet_a: assert property (
      !i_oc_event [*5] |=> !o_oc_response_apply)
      else $error("oc response without oc event");
   cover property (o_latched_off);
   cover property (o_hiccup);
   cover property (o_uv_fault && o_switch_enable);
endmodule // uvf_fault_response_chk
bind uvf_fault_response uvf_fault_response_chk u_chk (
   .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_en(i_en), .i_oc_event(i_oc_event),
   .i_otp(i_otp),
   .o_switch_enable(o_switch_enable), .o_soft_start(o_soft_start),
   .o_hiccup(o_hiccup), .o_latched_off(o_latched_off), .o_uv_fault(o_uv_fault),
   .o_current_limit_en(o_current_limit_en),
   .o_oc_response_apply(o_oc_response_apply),
   .o_input_ov_enable(o_input_ov_enable),
   .o_input_ov_threshold(o_input_ov_threshold));
`default_nettype wire

/* File: tb/uvf_host_model.sv */
`timescale 1ns/1ns
`default_nettype none
module uvf_host_model (
   input  wire logic       i_clk_sys,
   input  wire logic [7:0] i_reg_rdata,
   output var  logic       o_reg_wr_en,
   output var  logic [7:0] o_reg_addr,
   output var  logic [7:0] o_reg_wdata
);
   initial begin
      o_reg_wr_en = 1'b0;
      o_reg_addr = 8'h00;
      o_reg_wdata = 8'h00;
   end
   task wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge i_clk_sys);
      o_reg_wr_en <= 1'b1;
      o_reg_addr <= a;
      o_reg_wdata <= d;
      @(posedge i_clk_sys);
      o_reg_wr_en <= 1'b0;
      // data released: show inverse, not last value
      o_reg_wdata <= ~d;
   endtask
   task rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge i_clk_sys);
      o_reg_addr <= a;
      repeat (2) @(posedge i_clk_sys);
      d = i_reg_rdata;
   endtask
endmodule // uvf_host_model
`default_nettype wire

/* File: tb/tb.sv */
`timescale 1ns/1ns
`default_nettype none
`include "uvf_consts.vh"
module tb;
   logic        i_clk_sys = 1'b0;
   logic        i_rst = 1'b1;
   logic        en = 0, tick = 0, half = 0, q3 = 0, fall = 0;
   logic        ssd = 0, otp = 0, oc = 0, tick_d = 0;
   logic [2:0]  tcnt = 3'h0;
   logic [31:0] seed = 32'h141F5059;
   wire  [7:0]  rdata, addr, wdata;
   wire         wr_en, sw, ss, hic, lat, uvf, cl, oca, sel, ove, ovh;
   wire  [1:0]  ovt;
   int          errors = 0, compares = 0, cyc = 0, nticks = 0, n0;
   uvf_fault_response u_uvf_fault_response (
      .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_reg_wr_en(wr_en),
      .i_reg_addr(addr), .i_reg_wdata(wdata), .o_reg_rdata(rdata),
      .i_en(en), .i_sw_tick(tick), .i_fb_below_half(half),
      .i_fb_below_3q(q3), .i_vout_falling(fall), .i_ss_done(ssd),
      .i_otp(otp), .i_oc_event(oc), .o_switch_enable(sw),
      .o_soft_start(ss), .o_hiccup(hic), .o_latched_off(lat),
      .o_uv_fault(uvf), .o_current_limit_en(cl), .o_oc_response_apply(oca),
      .o_uv_threshold_select(sel), .o_input_ov_enable(ove),
      .o_input_ov_threshold(ovt), .o_input_ov_hysteresis(ovh));
   uvf_host_model u_host (.i_clk_sys(i_clk_sys), .i_reg_rdata(rdata),
      .o_reg_wr_en(wr_en), .o_reg_addr(addr), .o_reg_wdata(wdata));
   always #50 i_clk_sys = ~i_clk_sys;
   always @(posedge i_clk_sys) begin
      tcnt <= tcnt + 3'h1;
      tick <= tcnt[2];
      tick_d <= tick;
      if (tick && !tick_d) nticks <= nticks + 1;
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         errors = errors + 1;
         give_verdict();
      end
   end
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function automatic logic [7:0] trip_n(input logic [1:0] c);
      return 8'(`UVF_DB_BASE << c);
   endfunction
   task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      compares++;
      if (g !== e) begin
         errors++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask
   task give_verdict();
      $display("compares %0d errors %0d", compares, errors);
      if (errors == 0 && compares > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task cyc_n(input int n);
      repeat (n) @(posedge i_clk_sys);
   endtask
   task start_run(input logic [7:0] cfg);
      @(posedge i_clk_sys);
      {en, ssd, fall, half, q3} <= 5'h00;
      cyc_n(6);
      u_host.wr(`UVF_ADDR_UV_CFG, cfg);
      en <= 1'b1;
      cyc_n(8);
      chk("soft_start", 1, ss);
      {fall, half, q3} <= 3'h7;
      cyc_n(200);
      chk("ss_uv_ignored", 0, uvf);
      chk("ss_limit", 1, cl);
      {fall, ssd} <= 2'h1;
      cyc_n(6);
      chk("run_switch", 1, sw);
   endtask
   // start the uv condition mid-period so the next tick counts first
   task raise(input logic s);
      while (tcnt != 3'h2) @(posedge i_clk_sys);
      {fall, q3, half} <= {2'h3, !s};
      n0 = nticks;
   endtask
   task wait_uv();
      for (int k = 0; k < 400 && uvf !== 1'b1; k++) @(posedge i_clk_sys);
   endtask
   initial begin
      logic [7:0] d, r;
      logic       s;
      cyc_n(3);
      i_rst <= 1'b0;
      u_host.rd(`UVF_ADDR_UV_CFG, d);
      chk("uv_cfg_reset", `UVF_UV_CFG_RESET, d);
      u_host.wr(`UVF_ADDR_STATUS, rnd());
      u_host.rd(`UVF_ADDR_STATUS, d);
      chk("status_ro", 8'h01, d);
      u_host.rd(8'h33, d);
      chk("unmapped", `UVF_RDATA_NONE, d);
      for (int t = 0; t < 4; t++) begin
         r = rnd();
         u_host.wr(`UVF_ADDR_OV_CFG, {r[7], 2'(t), r[4:0]});
         u_host.rd(`UVF_ADDR_OV_CFG, d);
         chk("ov_cfg", {r[7], 2'(t), r[4:0]}, d);
         chk("ov_thr", 8'(t), ovt);
         chk("ov_enable", t != 0, ove);
         chk("ov_hys", r[7], ovh);
      end
      $display("registers done");
      for (int c = 0; c < 4; c++) begin
         s = c[0];
         start_run({3'h0, s, 2'(c), c[1] ? 2'h3 : 2'h2});
         chk("uv_select", s, sel);
         raise(s);
         while (nticks - n0 < trip_n(2'(c)) - 1) @(posedge i_clk_sys);
         if (s) fall <= 1'b0;
         else half <= 1'b0;
         cyc_n(12);
         chk("uv_early", 0, uvf);
         raise(s);
         wait_uv();
         chk("uv_ticks", trip_n(2'(c)), 8'(nticks - n0));
         chk("keep_switch", 1, sw);
         chk("oc_idle", 0, oca);
      end
      otp <= 1'b1;
      cyc_n(6);
      chk("otp_stop", 0, sw);
      {otp, oc} <= 2'h1;
      cyc_n(6);
      chk("oc_apply", 1, oca);
      oc <= 1'b0;
      $display("debounce done");
      start_run(8'h01);
      raise(1'b0);
      wait_uv();
      {fall, half, q3} <= 3'h0;
      cyc_n(100);
      chk("latched", 1, lat);
      chk("latch_sw", 0, sw);
      u_host.rd(`UVF_ADDR_STATUS, d);
      chk("status_latch", 8'h20, d);
      en <= 1'b0;
      cyc_n(6);
      chk("latch_clear", 0, lat);
      {en, ssd} <= 2'h2;
      cyc_n(6);
      chk("relaunch", 1, ss);
      $display("latch done");
      start_run(8'h00);
      raise(1'b0);
      wait_uv();
      {ssd, fall, half, q3} <= 4'h0;
      cyc_n(4);
      chk("delay_sw", 0, sw);
      chk("delay_hiccup", 0, hic);
      n0 = nticks;
      for (int k = 0; k < 1000 && ss !== 1'b1; k++) @(posedge i_clk_sys);
      chk("retry_ticks", `UVF_RETRY_PERIODS, 8'(nticks - n0));
      ssd <= 1'b1;
      cyc_n(6);
      raise(1'b0);
      wait_uv();
      cyc_n(4);
      chk("hiccup", 1, hic);
      $display("recover done");
      give_verdict();
   end
endmodule // tb
`default_nettype wire
